/* File: rtl/fifo_flag_pkg.sv */
// constants for the dual-clock buffer with standard and fall-through flags
// assumes a single system clock that oversamples both port clocks
package fifo_flag_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int DATA_W_DEF    = 20;
    localparam int DEPTH_DEF     = 32768;
    localparam int OFFSET_W      = 8;

    // ----------------------------------------------------------------
    // default offsets chosen by the two select straps at reset
    // ----------------------------------------------------------------
    localparam logic [OFFSET_W-1:0] OFFSET_HH = 8'hFF;
    localparam logic [OFFSET_W-1:0] OFFSET_LH = 8'h7F;
    localparam logic [OFFSET_W-1:0] OFFSET_HL = 8'h3F;
    localparam logic [OFFSET_W-1:0] OFFSET_LL = 8'h07;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    // read clock rises needed before the first word falls through
    localparam logic [1:0] FALL_EDGES    = 2'h3;
    // extra words for the almost-empty threshold, per mode
    localparam int         AE_EXTRA_STD  = 1;
    localparam int         AE_EXTRA_FALL_THROUGH_SELECT = 2;

    typedef enum logic
    {
        MODE_STANDARD = 1'b0,
        MODE_FALL     = 1'b1
    } flag_mode_t;

endpackage

/* File: rtl/dual_clock_fifo_flag_modes.sv */
// dual-clock first-in first-out buffer with two flag timing modes
// assumes write and read port clocks far slower than clk_sys_in; both
// are sampled as pins and their rising edges found on the system clock
//
// Overview of operation
// - mode strap sampled during reset, held after
// - standard: every word read by request
// - fall-through: first word out after three edges
// - write only with write enable low
// - standard: empty indicator high after first write
// - standard: almost-empty high at n+1 words
// - standard: almost-full low at depth minus m
// - standard: full low at depth, writes blocked
// - standard: read from full raises full
// - standard: almost-empty low at n words
// - standard: empty low after last read
// - standard: empty and full doubly registered
// - fall-through: output-valid low after first write
// - fall-through: almost-empty high at n+2 words
// - fall-through: depth is one word larger
// - fall-through: input-space high at depth
// - fall-through: read from full lowers input-space
// - fall-through: almost-empty low at n+1
// - fall-through: output-valid high after last read
// - fall-through: valid triple, space double registered
// - offset straps load both offsets at reset
`timescale 1ns/1ps

module dual_clock_fifo_flag_modes
    import fifo_flag_pkg::*;
#(
    parameter int DATA_W = DATA_W_DEF,
    parameter int DEPTH  = DEPTH_DEF
)
(
    input  wire logic              clk_sys_in,
    input  wire logic              rst_in,
    input  wire logic              write_clk_in,
    input  wire logic              write_enable_n_in,
    input  wire logic [DATA_W-1:0] data_in,
    input  wire logic              read_clk_in,
    input  wire logic              read_enable_n_in,
    input  wire logic              fall_through_select_in,
    input  wire logic              default_offset_select_lo_in,
    input  wire logic              default_offset_select_hi_in,
    output logic      [DATA_W-1:0] data_out,
    output logic                   empty_indicator_n_out,
    output logic                   full_indicator_n_out,
    output logic                   almost_empty_flag_n_out,
    output logic                   almost_full_flag_n_out,
    output logic                   input_space_n_out,
    output logic                   output_valid_n_out
);

    localparam int ADDR_W = $clog2(DEPTH);
    localparam int PTR_W  = ADDR_W + 1;
    localparam int PIN_W  = DATA_W + 7;
    localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(DEPTH - 1);

    // the pointers count freely for the flag arithmetic, while memory
    // addresses wrap at the last entry, so a depth that is not a power
    // of two still addresses only entries that exist
    function automatic logic [ADDR_W-1:0] addr_step(
        input logic [ADDR_W-1:0] a);
        addr_step = (a == LAST_ADDR) ? '0 : a + ADDR_W'(1);
    endfunction

    function automatic logic [PTR_W-1:0] to_gray(input logic [PTR_W-1:0] b);
        to_gray = b ^ (b >> 1);
    endfunction

    function automatic logic [PTR_W-1:0] from_gray(input logic [PTR_W-1:0] g);
        logic [PTR_W-1:0] b;
        b[PTR_W-1] = g[PTR_W-1];
        for (int i = PTR_W - 2; i >= 0; i--)
        begin
            b[i] = b[i+1] ^ g[i];
        end
        from_gray = b;
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [PIN_W-1:0]  pin_s1_r;
    logic [PIN_W-1:0]  pin_s2_r;
    logic              wclk_d_r;
    logic              rclk_d_r;
    logic              wclk_s;
    logic              wen_n_s;
    logic [DATA_W-1:0] din_s;
    logic              rclk_s;
    logic              ren_n_s;
    logic              ft_sel_s;
    logic              sel_lo_s;
    logic              sel_hi_s;
    logic              wclk_rise;
    logic              rclk_rise;

    // data rides the same two stages as its clock, so they stay aligned
    always_ff @(posedge clk_sys_in)
    begin
        pin_s1_r <= {write_clk_in, write_enable_n_in, data_in, read_clk_in,
                     read_enable_n_in, fall_through_select_in,
                     default_offset_select_lo_in,
                     default_offset_select_hi_in};
        pin_s2_r <= pin_s1_r;
    end

    assign {wclk_s, wen_n_s, din_s, rclk_s, ren_n_s, ft_sel_s, sel_lo_s,
            sel_hi_s} = pin_s2_r;

    always_ff @(posedge clk_sys_in)
    begin
        wclk_d_r <= wclk_s;
        rclk_d_r <= rclk_s;
    end

    assign wclk_rise = wclk_s & ~wclk_d_r;
    assign rclk_rise = rclk_s & ~rclk_d_r;

    // ----------------------------------------------------------------
    // straps caught while reset is held
    // ----------------------------------------------------------------
    flag_mode_t          mode_r;
    logic [OFFSET_W-1:0] offset_r;

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            mode_r <= ft_sel_s ? MODE_FALL : MODE_STANDARD;
            unique case ({sel_hi_s, sel_lo_s})
                2'b11: offset_r <= OFFSET_HH;
                2'b01: offset_r <= OFFSET_LH;
                2'b10: offset_r <= OFFSET_HL;
                2'b00: offset_r <= OFFSET_LL;
            endcase
        end
    end

    logic             fall;
    logic [PTR_W-1:0] cap;
    logic [PTR_W-1:0] offset_ext;

    assign fall       = (mode_r == MODE_FALL);
    // the output register adds one word of room in fall-through
    assign cap        = PTR_W'(DEPTH) + PTR_W'(fall);
    assign offset_ext = PTR_W'(offset_r);

    // ----------------------------------------------------------------
    // storage and write side
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] mem [DEPTH];
    logic [PTR_W-1:0]  wptr_r;
    logic [ADDR_W-1:0] wr_addr_r;
    logic [PTR_W-1:0]  cons_ptr_r;
    logic [PTR_W-1:0]  cons_g1_r;
    logic [PTR_W-1:0]  cons_g2_r;
    logic [PTR_W-1:0]  wr_count;
    logic              wr_full;
    logic              do_write;

    always_ff @(posedge clk_sys_in)
    begin
        cons_g1_r <= to_gray(cons_ptr_r);
        cons_g2_r <= cons_g1_r;
    end

    // write side sees a lagging consumer count, so it only errs toward full
    assign wr_count = wptr_r - from_gray(cons_g2_r);
    assign wr_full  = (wr_count >= cap);
    assign do_write = wclk_rise & ~wen_n_s & ~wr_full;

    always_ff @(posedge clk_sys_in)
    begin
        if (do_write)
        begin
            mem[wr_addr_r] <= din_s;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            wr_addr_r <= '0;
        end
        else if (do_write)
        begin
            wr_addr_r <= addr_step(wr_addr_r);
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            wptr_r <= '0;
        end
        else if (do_write)
        begin
            wptr_r <= wptr_r + PTR_W'(1);
        end
    end

    // full-side flags registered from the unregistered write-side count
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            full_indicator_n_out  <= 1'b1;
            input_space_n_out     <= 1'b0;
            almost_full_flag_n_out <= 1'b1;
        end
        else
        begin
            full_indicator_n_out  <= fall | ~wr_full;
            input_space_n_out     <= fall & wr_full;
            almost_full_flag_n_out <= ~(wr_count >= cap - offset_ext);
        end
    end

    // ----------------------------------------------------------------
    // read side
    // ----------------------------------------------------------------
    logic [PTR_W-1:0] wptr_g1_r;
    logic [PTR_W-1:0] wptr_g2_r;
    logic [PTR_W-1:0] wptr_rd;
    logic [PTR_W-1:0] fetch_ptr_r;
    logic [PTR_W-1:0] rd_count;
    logic             out_valid_r;
    logic             valid_pipe_r;
    logic [ADDR_W-1:0] cons_addr_r;
    logic [ADDR_W-1:0] fetch_addr_r;
    logic [1:0]       fall_cnt_r;
    logic             mem_avail;
    logic             std_read;
    logic             pop;
    logic             load_first;
    logic             load_next;
    logic [ADDR_W-1:0] rd_addr;

    always_ff @(posedge clk_sys_in)
    begin
        wptr_g1_r <= to_gray(wptr_r);
        wptr_g2_r <= wptr_g1_r;
    end

    assign wptr_rd   = from_gray(wptr_g2_r);
    // words stored, the output register included in fall-through
    assign rd_count  = wptr_rd - cons_ptr_r;
    assign mem_avail = (wptr_rd != fetch_ptr_r);

    // an empty buffer ignores read enable in both modes
    assign std_read   = ~fall & rclk_rise & ~ren_n_s & (rd_count != '0);
    assign pop        = fall & rclk_rise & ~ren_n_s & out_valid_r;
    assign load_next  = pop & mem_avail;
    assign load_first = fall & rclk_rise & ~out_valid_r & mem_avail
                        & (fall_cnt_r == FALL_EDGES - 2'h1);
    assign rd_addr    = fall ? fetch_addr_r : cons_addr_r;

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            cons_addr_r  <= '0;
            fetch_addr_r <= '0;
        end
        else
        begin
            if (std_read || pop)
            begin
                cons_addr_r <= addr_step(cons_addr_r);
            end
            if (load_first || load_next)
            begin
                fetch_addr_r <= addr_step(fetch_addr_r);
            end
        end
    end

    // counts read clock rises while a word waits behind an empty output
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in || out_valid_r || !fall)
        begin
            fall_cnt_r <= '0;
        end
        else if (rclk_rise && mem_avail)
        begin
            fall_cnt_r <= fall_cnt_r + 2'h1;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            out_valid_r <= 1'b0;
        end
        else if (load_first)
        begin
            out_valid_r <= 1'b1;
        end
        else if (pop && !mem_avail)
        begin
            out_valid_r <= 1'b0;
        end
    end

    // middle stage of the three that the output-valid pin passes
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            valid_pipe_r <= 1'b0;
        end
        else
        begin
            valid_pipe_r <= out_valid_r;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            cons_ptr_r  <= '0;
            fetch_ptr_r <= '0;
        end
        else
        begin
            if (std_read || pop)
            begin
                cons_ptr_r <= cons_ptr_r + PTR_W'(1);
            end
            if (load_first || load_next)
            begin
                fetch_ptr_r <= fetch_ptr_r + PTR_W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            data_out <= '0;
        end
        else if (std_read || load_first || load_next)
        begin
            data_out <= mem[rd_addr];
        end
    end

    // empty-side flags; thresholds differ by the output register word
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            empty_indicator_n_out   <= 1'b0;
            almost_empty_flag_n_out <= 1'b0;
            output_valid_n_out      <= 1'b1;
        end
        else
        begin
            empty_indicator_n_out <= fall | (rd_count != '0);
            output_valid_n_out    <= ~valid_pipe_r;
            if (fall)
            begin
                almost_empty_flag_n_out <=
                    (rd_count >= offset_ext + PTR_W'(AE_EXTRA_FALL_THROUGH_SELECT));
            end
            else
            begin
                almost_empty_flag_n_out <=
                    (rd_count >= offset_ext + PTR_W'(AE_EXTRA_STD));
            end
        end
    end

endmodule

/* File: dv/fifo_flag_properties.sv */
// checker for the flag and data outputs of the dual-clock buffer
// bound to the top module; straps are held steady through reset
`timescale 1ns/1ps
module fifo_flag_properties #(parameter int DATA_W = 20)
(
    input wire logic              clk_sys_in,
    input wire logic              rst_in,
    input wire logic              read_clk_in,
    input wire logic              read_enable_n_in,
    input wire logic              fall_through_select_in,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic              empty_indicator_n_out,
    input wire logic              full_indicator_n_out,
    input wire logic              almost_empty_flag_n_out,
    input wire logic              almost_full_flag_n_out,
    input wire logic              input_space_n_out,
    input wire logic              output_valid_n_out
);
    logic            mode_r;
    logic            rc_r;
    logic [4:0]      rd_age_r;
    logic [1:0]      rises_r;
    wire logic       rd_rise = read_clk_in && !rc_r;
    // order: empty, full, almost empty, almost full, space, valid
    wire logic [5:0] flags_w = {empty_indicator_n_out, full_indicator_n_out,
        almost_empty_flag_n_out, almost_full_flag_n_out,
        input_space_n_out, output_valid_n_out};

    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    always_ff @(posedge clk_sys_in)
    begin
        rc_r <= read_clk_in;
        if (rst_in)
            mode_r <= fall_through_select_in;
    end

    // age of the last requested read; pin time leads the design's view
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in || (rd_rise && !read_enable_n_in))
            rd_age_r <= '0;
        else if (rd_age_r != 5'h1F)
            rd_age_r <= rd_age_r + 5'h01;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in || !output_valid_n_out)
            rises_r <= '0;
        else if (rd_rise && rises_r != 2'h3)
            rises_r <= rises_r + 2'h1;
    end

    sequence s_word_falls;
        mode_r && $fell(output_valid_n_out);
    endsequence

    a_reset_flags: assert property ($fell(rst_in) |-> flags_w == 6'h15)
        else $error("flags not at reset values");
    a_std_idle: assert property (!mode_r |-> flags_w[1:0] == 2'h1)
        else $error("fall-through pins active in standard mode");
    a_ft_idle: assert property (
        mode_r && !$past(rst_in) |-> flags_w[5:4] == 2'h3)
        else $error("standard pins active in fall-through mode");
    a_full_af: assert property (!mode_r && !flags_w[4] |-> !flags_w[2])
        else $error("full without almost full");
    a_empty_ae: assert property (!mode_r && !flags_w[5] |-> !flags_w[3])
        else $error("empty without almost empty");
    a_full_release: assert property (
        $rose(flags_w[4]) |-> rd_age_r < 5'h14)
        else $error("full released without a read");
    a_std_data: assert property (
        !mode_r && $changed(data_out) |-> rd_age_r < 5'h0A)
        else $error("read data moved without a read");
    a_fall_three: assert property (s_word_falls |-> rises_r == 2'h3)
        else $error("word fell through before three read clock rises");
endmodule

bind dual_clock_fifo_flag_modes fifo_flag_properties #(.DATA_W(DATA_W)) u_props
(
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .read_clk_in(read_clk_in),
    .read_enable_n_in(read_enable_n_in),
    .fall_through_select_in(fall_through_select_in), .data_out(data_out),
    .empty_indicator_n_out(empty_indicator_n_out),
    .full_indicator_n_out(full_indicator_n_out),
    .almost_empty_flag_n_out(almost_empty_flag_n_out),
    .almost_full_flag_n_out(almost_full_flag_n_out),
    .input_space_n_out(input_space_n_out),
    .output_valid_n_out(output_valid_n_out)
);

/* File: dv/fifo_port_partner.sv */
// writer and reader models for the two ports of the buffer
// clocks run free; each request is held for one whole link period
`timescale 1ns/1ps
module fifo_port_partner
    import fifo_flag_pkg::*;
(
    input  wire logic                  rst_in,
    input  wire logic                  wr_go_in,
    input  wire logic                  rd_go_in,
    output logic                       write_clk_out,
    output logic                       write_enable_n_out,
    output logic      [DATA_W_DEF-1:0] word_out,
    output logic                       read_clk_out,
    output logic                       read_enable_n_out
);
    logic [DATA_W_DEF-1:0] next_word_r;

    // odd phases keep link edges clear of system clock edges
    initial
    begin
        write_clk_out = 1'b0;
        write_enable_n_out = 1'b1;
        word_out = '0;
        next_word_r = '0;
        #13;
        forever #200 write_clk_out = ~write_clk_out;
    end
    initial
    begin
        read_clk_out = 1'b0;
        read_enable_n_out = 1'b1;
        #137;
        forever #200 read_clk_out = ~read_clk_out;
    end

    // falling edge changes keep enable and data steady around each rise
    always @(negedge write_clk_out)
    begin
        write_enable_n_out <= !wr_go_in;
        if (rst_in)
            next_word_r <= '0;
        else if (wr_go_in)
            next_word_r <= next_word_r + 1'b1;
        // idle data is inverted so a stray capture shows up
        word_out <= wr_go_in ? next_word_r : ~word_out;
    end
    always @(negedge read_clk_out)
        read_enable_n_out <= !rd_go_in;
endmodule

/* File: dv/tb_dual_clock_fifo_flag_modes.sv */
// self-checking bench for the dual-clock buffer in both flag modes
// the port partner makes both link clocks; the bench drives straps
`timescale 1ns/1ps
module tb_dual_clock_fifo_flag_modes;
    import fifo_flag_pkg::*;
    localparam int DEPTH_T = 140;
    typedef struct { bit wr; int n; bit fill; } row_t;

    logic                  clk_sys_in = 1'b0;
    logic                  rst_in = 1'b1;
    logic                  ft_sel = 1'b0;
    logic [1:0]            sel = 2'h0;
    logic                  wr_go = 1'b0;
    logic                  rd_go = 1'b0;
    logic                  wclk, wen_n, rclk, ren_n;
    logic [DATA_W_DEF-1:0] word;
    wire  [DATA_W_DEF-1:0] q;
    wire  [5:0]            flags;
    int                    err_total = 0;
    int                    num_checks = 0;
    int                    cnt, rd_n, cap;
    int                    offs [4] = '{7, 127, 63, 255};
    row_t                  rows [4] = '{'{1, 3, 0}, '{0, 3, 0},
                                        '{1, 1, 1}, '{0, 1, 1}};

    always #25 clk_sys_in = ~clk_sys_in;

    fifo_port_partner partner
    (
        .rst_in(rst_in), .wr_go_in(wr_go), .rd_go_in(rd_go),
        .write_clk_out(wclk), .write_enable_n_out(wen_n), .word_out(word),
        .read_clk_out(rclk), .read_enable_n_out(ren_n)
    );
    dual_clock_fifo_flag_modes #(.DATA_W(DATA_W_DEF), .DEPTH(DEPTH_T)) dut
    (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .write_clk_in(wclk), .write_enable_n_in(wen_n), .data_in(word),
        .read_clk_in(rclk), .read_enable_n_in(ren_n),
        .fall_through_select_in(ft_sel),
        .default_offset_select_lo_in(sel[0]),
        .default_offset_select_hi_in(sel[1]),
        .data_out(q), .empty_indicator_n_out(flags[5]),
        .full_indicator_n_out(flags[4]), .almost_empty_flag_n_out(flags[3]),
        .almost_full_flag_n_out(flags[2]), .input_space_n_out(flags[1]),
        .output_valid_n_out(flags[0])
    );

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // order: empty, full, almost empty, almost full, space, valid
    function automatic logic [5:0] exp_flags(input bit ft, input int k);
        if (ft)
            return {2'h3, 1'(cnt >= k + 2), 1'(cnt < DEPTH_T + 1 - k),
                    1'(cnt == DEPTH_T + 1), 1'(cnt == 0)};
        return {1'(cnt != 0), 1'(cnt != DEPTH_T), 1'(cnt >= k + 1),
                1'(cnt < DEPTH_T - k), 2'h1};
    endfunction

    task automatic wait_fall(input bit rd);
        logic prev;
        logic now;
        prev = rd ? rclk : wclk;
        for (int i = 0; i < 40; i++)
        begin
            @(posedge clk_sys_in);
            now = rd ? rclk : wclk;
            if (prev && !now)
                return;
            prev = now;
        end
        err_total++;
        $display("[FAIL] %0t link clock stalled", $time);
        close_out();
    endtask

    // one word per request; the wait covers the three-rise fall-through
    task automatic do_op(input bit wr, input bit ft, input int k);
        if (ft && !wr && cnt > 0)
            check(q, rd_n);
        if (wr)
            wr_go <= 1'b1;
        else
            rd_go <= 1'b1;
        wait_fall(!wr);
        wr_go <= 1'b0;
        rd_go <= 1'b0;
        wait_fall(!wr);
        repeat (48) @(posedge clk_sys_in);
        if (wr && cnt < cap)
            cnt++;
        if (!wr && cnt > 0)
        begin
            cnt--;
            rd_n++;
        end
        if (!ft && !wr)
            check(q, rd_n - 1);
        check(flags, exp_flags(ft, k));
    endtask

    task automatic run_mode(input bit ft, input logic [1:0] s);
        rst_in <= 1'b1;
        ft_sel <= ft;
        sel <= s;
        cap = ft ? DEPTH_T + 1 : DEPTH_T;
        repeat (20) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        cnt = 0;
        rd_n = 0;
        @(posedge clk_sys_in);
        #1;
        check(flags, exp_flags(ft, offs[s]));
        @(posedge clk_sys_in);
        foreach (rows[r])
            for (int j = 0; j < rows[r].n + (rows[r].fill ? cap : 0); j++)
                do_op(rows[r].wr, ft, offs[s]);
        $display("mode %0d straps %0d done, checks %0d", ft, s, num_checks);
    endtask

    initial
    begin
        run_mode(1'b0, 2'h0);
        run_mode(1'b1, 2'h2);
        run_mode(1'b0, 2'h1);
        close_out();
    end
endmodule
